/* File: logic/coin_pkg.sv */
package coin_pkg;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned ADDR_W = 8;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_UPPER = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_LOWER = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_ADDVAL = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_CMPA = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CMPB = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_WINLO = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_WINHI = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_MASK = 8'h28;
  // control field positions
  localparam int unsigned CTRL_EN = 0;
  localparam int unsigned CTRL_RING = 1;
  localparam int unsigned CTRL_ADD = 2;
  localparam int unsigned CTRL_CLKSEL = 3;
  localparam int unsigned CTRL_DEC_LO = 4;
  localparam int unsigned CTRL_RANGE = 6;
  localparam int unsigned CTRL_MA_LO = 8;
  localparam int unsigned CTRL_MB_LO = 12;
  localparam int unsigned CTRL_W = 15;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 15'h0000;
  // status / mask bits
  localparam int unsigned ST_W = 2;
  localparam int unsigned ST_COIN = 0;
  localparam int unsigned ST_WIN = 1;
  // reset values
  localparam logic [CNT_W-1:0] UPPER_RESET = 32'hFFFFFFFF;
  localparam logic [CNT_W-1:0] ZERO = 32'h00000000;
  localparam logic [CNT_W-1:0] ONE = 32'h00000001;
  // input decode modes
  localparam logic [1:0] DEC_ONE_PHASE = 2'h0;
  localparam logic [1:0] DEC_CW_CCW = 2'h1;
  localparam logic [1:0] DEC_TWO_PHASE_X1 = 2'h2;
  // compare modes
  localparam logic [2:0] CMP_EQ = 3'h0;
  localparam logic [2:0] CMP_GE = 3'h1;
  localparam logic [2:0] CMP_LE = 3'h2;
  localparam logic [2:0] CMP_GT = 3'h3;
  localparam logic [2:0] CMP_LT = 3'h4;
  // counting clock periods
  localparam int unsigned CLK_PERIOD_PS = 10000;
  localparam int unsigned T_FAST_NS = 25;
  localparam int unsigned T_SLOW_NS = 1000;
  localparam int unsigned PRE_W = 8;
  localparam logic [PRE_W-1:0] FAST_CYC =
    PRE_W'((T_FAST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [PRE_W-1:0] SLOW_CYC =
    PRE_W'((T_SLOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [PRE_W-1:0] PRE_ONE = 8'h01;
endpackage

/* File: logic/coincidence_detect_counter.sv */
// How it works
// R1: each up-count pulse raises the count by one step: one, or addval when addition mode is on.
// R2: compare output goes high when count reaches the coincidence value.
// R3: coincidence pulses the output pin high then low and raises an interrupt.
// R4: range condition matches when compare A and compare B both hold.
// R5: mode A tests greater-or-equal, mode B less-or-equal; equal values give equality.
// R6: counting clock period is selectable; 25ns setting catches fast pulses.
// R7: edge detector gives add pulses and separate two-phase x1 subtract pulses.
// R8: ring mode with programmable upper and lower limits; counts only when enabled.
// R9: addition mode can be off so each edge moves the count by one.
// R10: coincidence result is sent out as an event to another counter unit.
// R11: 32-bit angle-window output detects coincidence; its rising edge interrupts.
// R12: output latch with set and reset together resolves to reset.
// R13: ring wraps past upper to lower, and below lower to upper.
`timescale 1ns/1ps
`default_nettype none
module coincidence_detect_counter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic phase_a,
  input wire logic phase_b,
  output logic match_out,
  output logic output_pin,
  output logic event_out,
  output logic window_out,
  output logic irq
);
  localparam int unsigned W = coin_pkg::CNT_W;

  typedef struct packed {
    logic [coin_pkg::CTRL_W-1:0] ctrl;
    logic [W-1:0] upper;
    logic [W-1:0] lower;
    logic [W-1:0] addval;
    logic [W-1:0] cmpa;
    logic [W-1:0] cmpb;
    logic [W-1:0] winlo;
    logic [W-1:0] winhi;
    logic [W-1:0] count;
    logic [coin_pkg::ST_W-1:0] status;
    logic [coin_pkg::ST_W-1:0] mask;
    logic [coin_pkg::PRE_W-1:0] prescale;
    logic add_pend;
    logic sub_pend;
    logic match;
    logic out_latch;
    logic event_pulse;
    logic window;
    logic irq_line;
    logic [31:0] rdata;
  } unit_s;

  unit_s q;
  unit_s next_q;

  pulse_decode_if dec ();

  pulse_edge_decoder edge_decoder (
    .pclk(pclk),
    .presetn(presetn),
    .phase_a(phase_a),
    .phase_b(phase_b),
    .dec(dec)
  );

  // mode switches at once; an edge in flight may decode under the old mode
  assign dec.mode = q.ctrl[coin_pkg::CTRL_DEC_LO +: 2];

  function automatic logic cmp_hold(input logic [2:0] mode, input logic [W-1:0] cnt,
                                    input logic [W-1:0] val);
    logic r;
    r = 1'b0;
    case (mode)
      coin_pkg::CMP_EQ: r = (cnt == val);
      coin_pkg::CMP_GE: r = (cnt >= val); // R5
      coin_pkg::CMP_LE: r = (cnt <= val); // R5
      coin_pkg::CMP_GT: r = (cnt > val);
      coin_pkg::CMP_LT: r = (cnt < val);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // both limit tests need the carry, so sums are one bit wider
  function automatic logic [W:0] wide_add(input logic [W-1:0] x, input logic [W-1:0] y);
    return {1'b0, x} + {1'b0, y};
  endfunction

  logic access;
  logic wr;
  logic mapped;

  always_comb begin
    mapped = 1'b0;
    case (paddr)
      coin_pkg::OFF_CTRL,
      coin_pkg::OFF_UPPER,
      coin_pkg::OFF_LOWER,
      coin_pkg::OFF_ADDVAL,
      coin_pkg::OFF_CMPA,
      coin_pkg::OFF_CMPB,
      coin_pkg::OFF_WINLO,
      coin_pkg::OFF_WINHI,
      coin_pkg::OFF_COUNT,
      coin_pkg::OFF_STATUS,
      coin_pkg::OFF_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign access = psel & penable;
  assign wr = access & pwrite & mapped;

  always_comb begin
    logic [W-1:0] step;
    logic [W:0] up_sum;
    logic [W:0] lo_sum;
    logic tick;
    logic go_up;
    logic go_down;
    logic ring;
    logic next_match;
    logic match_rise;
    logic next_window;
    logic win_rise;
    logic [coin_pkg::ST_W-1:0] set_bits;
    logic [coin_pkg::ST_W-1:0] clr_bits;
    step = coin_pkg::ONE;
    up_sum = '0;
    lo_sum = '0;
    tick = 1'b0;
    go_up = 1'b0;
    go_down = 1'b0;
    ring = 1'b0;
    next_match = 1'b0;
    match_rise = 1'b0;
    next_window = 1'b0;
    win_rise = 1'b0;
    set_bits = '0;
    clr_bits = '0;
    next_q = q;

    // counting clock: one count step per selected period
    tick = (q.prescale == coin_pkg::PRE_ONE); // R6
    if (tick) begin
      next_q.prescale = q.ctrl[coin_pkg::CTRL_CLKSEL] ? coin_pkg::SLOW_CYC : coin_pkg::FAST_CYC; // R6
    end else begin
      next_q.prescale = q.prescale - coin_pkg::PRE_ONE;
    end

    // edges wait for the next tick; a new edge in the tick cycle is kept
    go_up = tick & q.add_pend & ~q.sub_pend;
    go_down = tick & q.sub_pend & ~q.add_pend; // R7
    next_q.add_pend = (q.add_pend & ~tick) | dec.add_pulse;
    next_q.sub_pend = (q.sub_pend & ~tick) | dec.sub_pulse;

    step = q.ctrl[coin_pkg::CTRL_ADD] ? q.addval : coin_pkg::ONE; // R9
    ring = q.ctrl[coin_pkg::CTRL_RING];
    up_sum = wide_add(q.count, step);
    lo_sum = wide_add(q.lower, step);

    // linear mode parks at the limit rather than wrapping
    if (q.ctrl[coin_pkg::CTRL_EN]) begin // R8
      if (go_up) begin // R1
        if (up_sum > {1'b0, q.upper}) begin
          next_q.count = ring ? q.lower : q.upper; // R13
        end else begin
          next_q.count = up_sum[W-1:0]; // R1
        end
      end else if (go_down) begin
        if ({1'b0, q.count} < lo_sum) begin
          next_q.count = ring ? q.upper : q.lower; // R13
        end else begin
          next_q.count = q.count - step;
        end
      end
    end

    // compare block
    if (q.ctrl[coin_pkg::CTRL_RANGE]) begin
      next_match = cmp_hold(q.ctrl[coin_pkg::CTRL_MA_LO +: 3], q.count, q.cmpa)
                 & cmp_hold(q.ctrl[coin_pkg::CTRL_MB_LO +: 3], q.count, q.cmpb); // R4
    end else begin
      next_match = cmp_hold(q.ctrl[coin_pkg::CTRL_MA_LO +: 3], q.count, q.cmpa); // R2
    end
    next_q.match = next_match; // R2
    match_rise = next_match & ~q.match;

    // set/reset latch: set on coincidence, reset one cycle later
    if (q.out_latch) begin
      next_q.out_latch = 1'b0; // R12
    end else if (match_rise) begin
      next_q.out_latch = 1'b1; // R3
    end
    next_q.event_pulse = match_rise; // R10

    // inclusive on both ends, so winlo equal to winhi marks one count
    next_window = (q.count >= q.winlo) & (q.count <= q.winhi); // R11
    next_q.window = next_window;
    win_rise = next_window & ~q.window; // R11

    set_bits[coin_pkg::ST_COIN] = match_rise; // R3
    set_bits[coin_pkg::ST_WIN] = win_rise; // R11

    // register writes
    if (wr) begin
      case (paddr)
        coin_pkg::OFF_CTRL: begin
          next_q.ctrl = pwdata[coin_pkg::CTRL_W-1:0];
        end
        coin_pkg::OFF_UPPER: begin
          next_q.upper = pwdata;
        end
        coin_pkg::OFF_LOWER: begin
          next_q.lower = pwdata;
        end
        coin_pkg::OFF_ADDVAL: begin
          next_q.addval = pwdata;
        end
        coin_pkg::OFF_CMPA: begin
          next_q.cmpa = pwdata;
        end
        coin_pkg::OFF_CMPB: begin
          next_q.cmpb = pwdata;
        end
        coin_pkg::OFF_WINLO: begin
          next_q.winlo = pwdata;
        end
        coin_pkg::OFF_WINHI: begin
          next_q.winhi = pwdata;
        end
        // preset overrides a count step in the same cycle
        coin_pkg::OFF_COUNT: begin
          next_q.count = pwdata;
        end
        // write one to clear
        coin_pkg::OFF_STATUS: begin
          clr_bits = pwdata[coin_pkg::ST_W-1:0];
        end
        coin_pkg::OFF_MASK: begin
          next_q.mask = pwdata[coin_pkg::ST_W-1:0];
        end
        default: begin
          clr_bits = '0;
        end
      endcase
    end
    // a new event in the clearing cycle survives
    next_q.status = (q.status & ~clr_bits) | set_bits;
    next_q.irq_line = |(next_q.status & next_q.mask); // R3 R11

    // read data captured in the setup cycle, presented in the access cycle
    if (psel & ~penable) begin
      case (paddr)
        coin_pkg::OFF_CTRL: next_q.rdata = 32'(q.ctrl);
        coin_pkg::OFF_UPPER: next_q.rdata = q.upper;
        coin_pkg::OFF_LOWER: next_q.rdata = q.lower;
        coin_pkg::OFF_ADDVAL: next_q.rdata = q.addval;
        coin_pkg::OFF_CMPA: next_q.rdata = q.cmpa;
        coin_pkg::OFF_CMPB: next_q.rdata = q.cmpb;
        coin_pkg::OFF_WINLO: next_q.rdata = q.winlo;
        coin_pkg::OFF_WINHI: next_q.rdata = q.winhi;
        coin_pkg::OFF_COUNT: next_q.rdata = q.count;
        coin_pkg::OFF_STATUS: next_q.rdata = 32'(q.status);
        coin_pkg::OFF_MASK: next_q.rdata = 32'(q.mask);
        default: next_q.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.ctrl <= coin_pkg::CTRL_RESET;
      q.upper <= coin_pkg::UPPER_RESET;
      q.lower <= coin_pkg::ZERO;
      q.prescale <= coin_pkg::PRE_ONE;
    end else begin
      q <= next_q;
    end
  end

  assign prdata = q.rdata;
  // zero wait states: every register answers from flops
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign match_out = q.match;
  assign output_pin = q.out_latch;
  assign event_out = q.event_pulse;
  assign window_out = q.window;
  assign irq = q.irq_line;
endmodule
`default_nettype wire

/* File: logic/pulse_decode_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface pulse_decode_if;
  logic [1:0] mode;
  logic add_pulse;
  logic sub_pulse;
  modport edge_side (input mode, output add_pulse, output sub_pulse);
  modport count_side (output mode, input add_pulse, input sub_pulse);
endinterface
`default_nettype wire

/* File: logic/pulse_edge_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module pulse_edge_decoder (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic phase_a,
  input wire logic phase_b,
  pulse_decode_if.edge_side dec
);
  typedef struct packed {
    logic a_s1;
    logic a_s2;
    logic a_d;
    logic b_s1;
    logic b_s2;
    logic b_d;
    logic add;
    logic sub;
  } dec_s;

  dec_s q;
  dec_s next_q;

  always_comb begin
    logic a_rise;
    logic a_fall;
    logic b_rise;
    a_rise = 1'b0;
    a_fall = 1'b0;
    b_rise = 1'b0;
    next_q = q;
    next_q.a_s1 = phase_a;
    next_q.a_s2 = q.a_s1;
    next_q.a_d = q.a_s2;
    next_q.b_s1 = phase_b;
    next_q.b_s2 = q.b_s1;
    next_q.b_d = q.b_s2;
    a_rise = q.a_s2 & ~q.a_d;
    a_fall = ~q.a_s2 & q.a_d;
    b_rise = q.b_s2 & ~q.b_d;
    next_q.add = 1'b0;
    next_q.sub = 1'b0;
    case (dec.mode)
      coin_pkg::DEC_ONE_PHASE: begin
        next_q.add = a_rise; // R7
      end
      coin_pkg::DEC_CW_CCW: begin
        next_q.add = a_rise; // R7
        next_q.sub = b_rise;
      end
      coin_pkg::DEC_TWO_PHASE_X1: begin
        // x1 quadrature: one count per full cycle of phase a, direction from b
        next_q.add = a_rise & ~q.b_s2; // R7
        next_q.sub = a_fall & ~q.b_s2; // R7
      end
      default: begin
        next_q.add = 1'b0;
        next_q.sub = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign dec.add_pulse = q.add;
  assign dec.sub_pulse = q.sub;
endmodule
`default_nettype wire

/* File: verification/coin_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module coin_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic match_out,
  input wire logic output_pin,
  input wire logic event_out,
  input wire logic window_out,
  input wire logic irq
);
  logic [1:0] mask_q;
  logic hit;
  assign hit = paddr <= coin_pkg::OFF_MASK && paddr[1:0] == 2'h0;
  // shadow of the mask, so irq can be tied to its enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= 2'h0;
    end else if (psel && penable && pready && pwrite && paddr == coin_pkg::OFF_MASK) begin
      mask_q <= pwdata[1:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  bus_error_a: assert property (pslverr == (psel && penable && !hit))
    else $error("slave error not matching address map");
  error_data_a: assert property (psel && penable && !pwrite && !hit |-> prdata == 32'h0)
    else $error("unmapped read returned data");
  pin_pulse_a: assert property ($rose(match_out) |-> output_pin ##1 !output_pin)
    else $error("output pin not a single pulse on match");
  pin_cause_a: assert property (output_pin |-> $rose(match_out))
    else $error("output pin high without match rise");
  event_link_a: assert property ($rose(match_out) |-> event_out ##1 !event_out)
    else $error("event pulse missing on match");
  irq_coin_a: assert property ($rose(match_out) && mask_q[0] |-> irq)
    else $error("no interrupt on coincidence");
  irq_window_a: assert property ($rose(window_out) && mask_q[1] |-> irq)
    else $error("no interrupt on window rise");
  irq_masked_a: assert property (irq |-> mask_q != 2'h0)
    else $error("interrupt with all sources masked");
  cover property ($rose(match_out));
  cover property ($rose(window_out));
  cover property (pslverr);
endmodule
`default_nettype wire

/* File: verification/pulse_src.sv */
`timescale 1ns/1ps
`default_nettype none
module pulse_src (
  input wire logic pclk,
  output logic phase_a,
  output logic phase_b
);
  initial begin
    phase_a = 1'b0;
    phase_b = 1'b0;
  end
  // each level held 4 cycles: longer than the two sync flops plus the edge register
  task automatic step(input logic a, input logic b);
    @(posedge pclk);
    phase_a <= a;
    phase_b <= b;
    repeat (3) @(posedge pclk);
  endtask
  task automatic up_a();
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  task automatic up_b();
    step(1'b0, 1'b1);
    step(1'b0, 1'b0);
  endtask
  // reverse quadrature: only the last edge (a falls, b low) counts
  task automatic quad_down();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, err, phase_a, phase_b;
  logic match_out, output_pin, event_out, window_out, irq;
  int n_fail = 0;
  int checks_done = 0;
  int pin_n = 0;
  int ev_n = 0;
  always #5 pclk = ~pclk;
  // counted on the falling edge, away from the design's updates
  always @(negedge pclk) begin
    if (output_pin === 1'b1) pin_n++;
    if (event_out === 1'b1) ev_n++;
  end
  coincidence_detect_counter i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .phase_a(phase_a), .phase_b(phase_b), .match_out(match_out),
    .output_pin(output_pin), .event_out(event_out), .window_out(window_out), .irq(irq));
  pulse_src i_src (.pclk(pclk), .phase_a(phase_a), .phase_b(phase_b));
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_fail++;
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // return mid-cycle so callers see settled outputs
    @(negedge pclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h00000000);
    chk($sformatf("register %h", a), exp, rdat);
  endtask
  // count step lands within sync delay plus one tick
  task automatic settle();
    repeat (12) @(negedge pclk);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    n_fail++;
    summarize();
  end
  initial begin
    int p0, e0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(coin_pkg::OFF_UPPER, coin_pkg::UPPER_RESET);
    rd(coin_pkg::OFF_CTRL, 32'h00000000);
    xfer(1'b0, 8'h40, 32'h00000000);
    chk("unmapped error", 32'h00000001, err);
    chk("unmapped data", 32'h00000000, rdat);
    wr(coin_pkg::OFF_UPPER, 32'h000007D0);
    wr(coin_pkg::OFF_WINLO, 32'h000007D0);
    wr(coin_pkg::OFF_WINHI, 32'h000007D0);
    wr(coin_pkg::OFF_CMPA, 32'h000003E8);
    wr(coin_pkg::OFF_CMPB, 32'h000003E8);
    wr(coin_pkg::OFF_COUNT, 32'h000003E6);
    // enable, ring, range, mode a >=, mode b <=
    wr(coin_pkg::OFF_CTRL, 32'h00002143);
    wr(coin_pkg::OFF_STATUS, 32'h00000003);
    wr(coin_pkg::OFF_MASK, 32'h00000001);
    chk("irq idle", 32'h00000000, irq);
    p0 = pin_n;
    e0 = ev_n;
    i_src.up_a();
    i_src.up_a();
    settle();
    chk("match", 32'h00000001, match_out);
    rd(coin_pkg::OFF_COUNT, 32'h000003E8);
    chk("pin pulses", 32'h00000001, pin_n - p0);
    chk("events", 32'h00000001, ev_n - e0);
    chk("irq", 32'h00000001, irq);
    rd(coin_pkg::OFF_STATUS, 32'h00000001);
    i_src.up_a();
    settle();
    chk("match past", 32'h00000000, match_out);
    wr(coin_pkg::OFF_STATUS, 32'h00000001);
    chk("irq cleared", 32'h00000000, irq);
    wr(coin_pkg::OFF_MASK, 32'h00000002);
    wr(coin_pkg::OFF_COUNT, 32'h000007D0);
    settle();
    chk("window", 32'h00000001, window_out);
    chk("irq window", 32'h00000001, irq);
    i_src.up_a();
    settle();
    rd(coin_pkg::OFF_COUNT, 32'h00000000);
    chk("window left", 32'h00000000, window_out);
    wr(coin_pkg::OFF_STATUS, 32'h00000003);
    wr(coin_pkg::OFF_CTRL, 32'h00002153);
    i_src.up_b();
    settle();
    rd(coin_pkg::OFF_COUNT, 32'h000007D0);
    i_src.up_a();
    settle();
    rd(coin_pkg::OFF_COUNT, 32'h00000000);
    wr(coin_pkg::OFF_COUNT, 32'h00000005);
    wr(coin_pkg::OFF_CTRL, 32'h00002163);
    i_src.quad_down();
    settle();
    rd(coin_pkg::OFF_COUNT, 32'h00000004);
    wr(coin_pkg::OFF_ADDVAL, 32'h00000003);
    wr(coin_pkg::OFF_CTRL, 32'h00002147);
    i_src.up_a();
    settle();
    rd(coin_pkg::OFF_COUNT, 32'h00000007);
    wr(coin_pkg::OFF_CTRL, 32'h00002142);
    i_src.up_a();
    settle();
    rd(coin_pkg::OFF_COUNT, 32'h00000007);
    // linear mode parks at the upper limit
    wr(coin_pkg::OFF_COUNT, 32'h000007D0);
    wr(coin_pkg::OFF_CTRL, 32'h00002141);
    i_src.up_a();
    settle();
    rd(coin_pkg::OFF_COUNT, 32'h000007D0);
    // slow counting clock: the step waits for the next long tick
    wr(coin_pkg::OFF_COUNT, 32'h00000005);
    wr(coin_pkg::OFF_CTRL, 32'h0000214B);
    i_src.up_a();
    settle();
    rd(coin_pkg::OFF_COUNT, 32'h00000005);
    repeat (100) @(negedge pclk);
    rd(coin_pkg::OFF_COUNT, 32'h00000006);
    // single compare in greater, less and equal modes
    wr(coin_pkg::OFF_CTRL, 32'h00000300);
    wr(coin_pkg::OFF_CMPA, 32'h00000005);
    settle();
    chk("match greater", 32'h00000001, match_out);
    wr(coin_pkg::OFF_CTRL, 32'h00000400);
    settle();
    chk("match less", 32'h00000000, match_out);
    wr(coin_pkg::OFF_CTRL, 32'h00000000);
    wr(coin_pkg::OFF_CMPA, 32'h00000006);
    settle();
    chk("match equal", 32'h00000001, match_out);
    summarize();
  end
endmodule
bind coincidence_detect_counter coin_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .match_out(match_out), .output_pin(output_pin), .event_out(event_out),
  .window_out(window_out), .irq(irq));
`default_nettype wire
